// *** core/wdt_wake_pkg.sv ***
// Purpose: Shared constants and types for the watchdog and wake-up controller.
// Assumes: APB register map with 32-bit aligned words; one 250 MHz clock.
// Notes:   Rules below; offsets are byte addresses.
// Operation
// - Four events end power-down
// - Reset wake full reset, watchdog wake PC/SP reset
// - Power-down flag: power-up/clear clears, sleep sets
// - Sleep time-out sets flag, resets PC/SP only
// - Running time-out resets device, sets flag
// - Wake enable per pin, nibble elsewhere
// - Pin wake resumes after sleep, no reset
// - Blocked interrupt wake resumes, stays pending
// - Allowed interrupt wake takes normal response
// - Already-set request cannot wake
// - 1024-cycle start-up after every wake
// - Interrupt entry at least one cycle later
// - Six-bit prescaler plus clearable final bit
// - Clear instruction resets only final stage
// - Watchdog disabled: its instructions do nothing
// - Reset pin, clear, sleep clear count
// - Option picks single or paired clearing
// - Paired clearing needs strict alternation
// - Own oscillator keeps running in power-down
// - Sleep: own clock continues, system clock stops
// - Entering power-down sets/clears flags, stops oscillator

package wdt_wake_pkg;

	// Register byte offsets
	localparam logic [11:0] CONFIG_OFFSET    = 12'h000;
	localparam logic [11:0] WAKE_MASK_OFFSET = 12'h004;
	localparam logic [11:0] STATUS_OFFSET    = 12'h008;
	localparam logic [11:0] COUNT_OFFSET     = 12'h00C;

	// Configuration register fields
	localparam int CFG_WDT_ENABLE_BIT = 0;
	localparam int CFG_OSC_ENABLE_BIT = 1;
	localparam int CFG_SRC_SYS_BIT    = 2;
	localparam int CFG_PAIR_MODE_BIT  = 3;
	localparam logic [3:0] CONFIG_RESET = 4'h3;

	// Wake mask register fields
	localparam int MASK_PORT_A_LSB  = 0;
	localparam int MASK_NIBBLE_LSB  = 8;
	localparam logic [7:0] MASK_PORT_A_RESET = 8'h00;

	// Status register fields
	localparam int STAT_TIMEOUT_BIT = 0;
	localparam int STAT_PDOWN_BIT   = 1;
	localparam int STAT_CAUSE_LSB   = 4;
	localparam int STAT_STATE_LSB   = 8;

	// Watchdog divider and start-up delay
	localparam int PRESCALE_BITS      = 6;
	localparam logic [5:0] PRESCALE_TOP = 6'h3F;
	localparam int STARTUP_CYCLES     = 1024;
	localparam int STARTUP_BITS       = 11;
	localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_CYCLES - 1);

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_SLEEP = 2'b01,
		ST_START = 2'b10,
		ST_GAP   = 2'b11
	} pm_state_t;

	typedef enum logic [2:0] {
		CAUSE_NONE  = 3'b000,
		CAUSE_RESET = 3'b001,
		CAUSE_PIN   = 3'b010,
		CAUSE_IRQ   = 3'b011,
		CAUSE_WDT   = 3'b100
	} wake_cause_t;

	typedef enum logic [1:0] {
		PAIR_NONE   = 2'b00,
		PAIR_FIRST  = 2'b01,
		PAIR_SECOND = 2'b10
	} pair_state_t;

endpackage : wdt_wake_pkg

// *** core/watchdog_and_wakeup_control.sv ***
// Purpose: Watchdog divider, clear instruction handling and power-down wake-up sequencing.
// Assumes: Core gives one-cycle instruction strobes; pins and oscillator are asynchronous.
// Notes:   Power-down is modelled by stalling the core; the system clock itself keeps running.

`timescale 1ns/1ps
`default_nettype none

module watchdog_and_wakeup_control #(
	parameter int OTHER_NIBBLES = 7, // Wake nibbles on ports other than the first
	parameter int SYS_DIV       = 4  // System clock division when it feeds the watchdog
) (
	input  wire logic                       clock,              // 250 MHz system clock
	input  wire logic                       rst,                // Power-on reset, sync high
	input  wire logic                       psel,               // APB select
	input  wire logic                       penable,            // APB enable
	input  wire logic                       pwrite,             // APB direction
	input  wire logic [11:0]                paddr,              // APB byte address
	input  wire logic [31:0]                pwdata,             // APB write data
	output logic      [31:0]                prdata,             // APB read data
	output logic                            pready,             // APB ready
	output logic                            pslverr,            // APB error on unmapped
	input  wire logic                       wdt_osc,            // Watchdog RC oscillator pin
	input  wire logic                       ext_reset_n,        // External reset pin, low active
	input  wire logic [7:0]                 port_a_pins,        // First port pins
	input  wire logic [4*OTHER_NIBBLES-1:0] port_other_pins,    // Remaining port pins
	input  wire logic                       irq_request,        // Any interrupt request flag set
	input  wire logic                       irq_enabled,        // Pending interrupt is enabled
	input  wire logic                       stack_full,         // No free stack level
	input  wire logic                       watchdog_clear_single, // Single clear instruction
	input  wire logic                       watchdog_clear_first,  // First paired clear
	input  wire logic                       watchdog_clear_second, // Second paired clear
	input  wire logic                       sleep_instr,        // Sleep instruction executed
	output logic                            timeout_flag,       // Watchdog time-out status
	output logic                            powerdown_flag,     // Power-down status
	output logic                            core_stall,         // Core held off
	output logic                            sys_osc_run,        // System oscillator enable
	output logic                            system_reset_req,   // Full reset pulse
	output logic                            watchdog_reset_req, // Device reset pulse
	output logic                            pc_sp_reset_req,    // Warm reset pulse
	output logic                            resume_req,         // Continue after sleep pulse
	output logic                            irq_service_req     // Take interrupt pulse
);

	localparam int OW = 4 * OTHER_NIBBLES;

	// The divider counter and the nibble slices are sized for these ranges
	initial begin
		if (OTHER_NIBBLES < 1 || OTHER_NIBBLES > 24) begin
			$error("OTHER_NIBBLES must be 1 to 24");
		end
		if (SYS_DIV < 1 || SYS_DIV > 256) begin
			$error("SYS_DIV must be 1 to 256");
		end
	end

	// All state in one record; request pulses drop back to zero each cycle
	typedef struct packed {
		logic [31:0]                prdata;
		logic                       pready;
		logic                       pslverr;
		logic [3:0]                 cfg;
		logic [7:0]                 mask_a;
		logic [OTHER_NIBBLES-1:0]   mask_nib;
		logic                       osc_s1;
		logic                       osc_s2;
		logic                       osc_prev;
		logic                       rn_s1;
		logic                       rn_s2;
		logic [7:0]                 a_s1;
		logic [7:0]                 a_s2;
		logic [7:0]                 a_prev;
		logic [OW-1:0]              o_s1;
		logic [OW-1:0]              o_s2;
		logic [OW-1:0]              o_prev;
		logic [7:0]                 sys_div;
		logic [5:0]                 prescale;
		logic                       final_bit;
		wdt_wake_pkg::pair_state_t  pair;
		wdt_wake_pkg::pm_state_t    state;
		wdt_wake_pkg::wake_cause_t  cause;
		logic [10:0]                startup;
		logic                       irq_at_sleep;
		logic                       timeout_flag;
		logic                       powerdown_flag;
		logic                       core_stall;
		logic                       sys_osc_run;
		logic                       system_reset_req;
		logic                       watchdog_reset_req;
		logic                       pc_sp_reset_req;
		logic                       resume_req;
		logic                       irq_service_req;
	} ctl_t;

	ctl_t r_reg;
	ctl_t r_next;

	// One wake bit per nibble: any pin of an enabled nibble falling
	function automatic logic [OTHER_NIBBLES-1:0] nibble_fall(
		input logic [OW-1:0]            prev,
		input logic [OW-1:0]            now,
		input logic [OTHER_NIBBLES-1:0] en
	);
		logic [OTHER_NIBBLES-1:0] hit;
		hit = '0;
		for (int i = 0; i < OTHER_NIBBLES; i++) begin
			hit[i] = en[i] & |(prev[4*i +: 4] & ~now[4*i +: 4]);
		end
		return hit;
	endfunction : nibble_fall

	logic wdt_en;
	logic osc_en;
	logic src_sys;
	logic pair_mode;
	logic sys_tick;
	logic wdt_tick;
	logic wdt_timeout;
	logic clr_hit;
	logic sleep_go;
	logic reset_low;
	logic pin_wake;
	logic irq_wake;
	logic in_run;
	logic setup_ph;
	logic wr_take;
	logic mapped;

	always_comb begin
		r_next = r_reg;
		r_next.system_reset_req   = 1'b0;
		r_next.watchdog_reset_req = 1'b0;
		r_next.pc_sp_reset_req    = 1'b0;
		r_next.resume_req         = 1'b0;
		r_next.irq_service_req    = 1'b0;

		wdt_en    = r_reg.cfg[wdt_wake_pkg::CFG_WDT_ENABLE_BIT];
		osc_en    = r_reg.cfg[wdt_wake_pkg::CFG_OSC_ENABLE_BIT];
		src_sys   = r_reg.cfg[wdt_wake_pkg::CFG_SRC_SYS_BIT];
		pair_mode = r_reg.cfg[wdt_wake_pkg::CFG_PAIR_MODE_BIT];
		in_run    = (r_reg.state == wdt_wake_pkg::ST_RUN);

		// Two-stage synchronisers; only the second stage and its delayed copy are looked at
		r_next.osc_s1   = wdt_osc;
		r_next.osc_s2   = r_reg.osc_s1;
		r_next.osc_prev = r_reg.osc_s2;
		r_next.rn_s1    = ext_reset_n;
		r_next.rn_s2    = r_reg.rn_s1;
		r_next.a_s1     = port_a_pins;
		r_next.a_s2     = r_reg.a_s1;
		r_next.a_prev   = r_reg.a_s2;
		r_next.o_s1     = port_other_pins;
		r_next.o_s2     = r_reg.o_s1;
		r_next.o_prev   = r_reg.o_s2;
		reset_low       = ~r_reg.rn_s2;

		pin_wake = |(r_reg.a_prev & ~r_reg.a_s2 & r_reg.mask_a)
			| |nibble_fall(r_reg.o_prev, r_reg.o_s2, r_reg.mask_nib);
		// A request already standing at sleep entry is masked out
		irq_wake = irq_request & ~r_reg.irq_at_sleep;

		// System clock source: divider only runs in the run state, not in power-down, start-up or the gap cycle
		sys_tick = 1'b0;
		if (in_run) begin
			if (r_reg.sys_div == 8'(SYS_DIV - 1)) begin
				r_next.sys_div = 8'h00;
				sys_tick       = 1'b1;
			end else begin
				r_next.sys_div = r_reg.sys_div + 8'h01;
			end
		end
		// Own oscillator source keeps ticking through power-down
		wdt_tick = wdt_en & (src_sys ? sys_tick : (osc_en & r_reg.osc_s2 & ~r_reg.osc_prev));

		// Clear instructions are ignored unless the watchdog is enabled
		clr_hit = 1'b0;
		if (wdt_en && in_run) begin
			if (!pair_mode) begin
				clr_hit = watchdog_clear_single;
			end else if (watchdog_clear_first) begin
				clr_hit        = (r_reg.pair == wdt_wake_pkg::PAIR_SECOND);
				r_next.pair    = clr_hit ? wdt_wake_pkg::PAIR_NONE : wdt_wake_pkg::PAIR_FIRST;
			end else if (watchdog_clear_second) begin
				clr_hit        = (r_reg.pair == wdt_wake_pkg::PAIR_FIRST);
				r_next.pair    = clr_hit ? wdt_wake_pkg::PAIR_NONE : wdt_wake_pkg::PAIR_SECOND;
			end
		end

		// Prescaler feeds the final stage; overflow of the final stage is the time-out
		wdt_timeout = wdt_tick & (r_reg.prescale == wdt_wake_pkg::PRESCALE_TOP)
			& r_reg.final_bit;
		// A time-out in the same cycle wins; that sleep is dropped
		sleep_go = in_run & sleep_instr & ~wdt_timeout;
		if (wdt_tick) begin
			r_next.prescale = r_reg.prescale + 6'h01;
			if (r_reg.prescale == wdt_wake_pkg::PRESCALE_TOP) begin
				r_next.final_bit = ~r_reg.final_bit;
			end
		end
		// Residual prescale count survives, hence the factor-of-two spread
		if (clr_hit || sleep_go) begin
			r_next.final_bit = 1'b0;
		end
		// The pin clears the whole count, not only the final stage
		if (reset_low) begin
			r_next.prescale  = 6'h00;
			r_next.final_bit = 1'b0;
			r_next.pair      = wdt_wake_pkg::PAIR_NONE;
		end

		// Flags: a set in the same cycle as a clear wins
		if (clr_hit || (reset_low && r_reg.state == wdt_wake_pkg::ST_SLEEP)) begin
			r_next.powerdown_flag = 1'b0;
		end
		if (sleep_go) begin
			r_next.powerdown_flag = 1'b1;
		end
		if (sleep_go || (reset_low && r_reg.state == wdt_wake_pkg::ST_SLEEP)) begin
			r_next.timeout_flag = 1'b0;
		end
		if (wdt_timeout) begin
			r_next.timeout_flag = 1'b1;
		end

		// Run, power-down, start-up delay, then one gap cycle for interrupt entry
		case (r_reg.state)
			wdt_wake_pkg::ST_RUN: begin
				if (wdt_timeout) begin
					r_next.watchdog_reset_req = 1'b1;
				end else if (sleep_go) begin
					r_next.state        = wdt_wake_pkg::ST_SLEEP;
					r_next.irq_at_sleep = irq_request;
				end
			end
			wdt_wake_pkg::ST_SLEEP: begin
				// A request present at entry must drop before it can wake
				r_next.irq_at_sleep = r_reg.irq_at_sleep & irq_request;
				if (reset_low || wdt_timeout || pin_wake || irq_wake) begin
					r_next.state   = wdt_wake_pkg::ST_START;
					r_next.startup = '0;
					if (reset_low) begin
						r_next.cause = wdt_wake_pkg::CAUSE_RESET;
					end else if (wdt_timeout) begin
						r_next.cause = wdt_wake_pkg::CAUSE_WDT;
					end else if (pin_wake) begin
						r_next.cause = wdt_wake_pkg::CAUSE_PIN;
					end else begin
						r_next.cause = wdt_wake_pkg::CAUSE_IRQ;
					end
				end
			end
			wdt_wake_pkg::ST_START: begin
				// Oscillator runs again; the core stays stalled until the count ends
				r_next.startup = r_reg.startup + 11'h001;
				if (r_reg.startup == wdt_wake_pkg::STARTUP_LAST) begin
					r_next.state = wdt_wake_pkg::ST_RUN;
					case (r_reg.cause)
						wdt_wake_pkg::CAUSE_RESET: begin
							r_next.system_reset_req = 1'b1;
						end
						wdt_wake_pkg::CAUSE_WDT: begin
							r_next.pc_sp_reset_req = 1'b1;
						end
						wdt_wake_pkg::CAUSE_IRQ: begin
							if (irq_enabled && !stack_full) begin
								r_next.state = wdt_wake_pkg::ST_GAP;
							end else begin
								r_next.resume_req = 1'b1;
							end
						end
						default: begin
							r_next.resume_req = 1'b1;
						end
					endcase
				end
			end
			wdt_wake_pkg::ST_GAP: begin
				// Interrupt entry trails the start-up delay by this one cycle
				r_next.irq_service_req = 1'b1;
				r_next.state           = wdt_wake_pkg::ST_RUN;
			end
			default: begin
				r_next.state = wdt_wake_pkg::ST_RUN;
			end
		endcase
		// Taken from the next state so both change in the same cycle as it
		r_next.core_stall  = (r_next.state != wdt_wake_pkg::ST_RUN);
		r_next.sys_osc_run = (r_next.state != wdt_wake_pkg::ST_SLEEP);

		// APB slave: answer in the first access cycle
		setup_ph = psel & ~penable;
		wr_take  = psel & penable & r_reg.pready & pwrite;
		// Whole words only; other addresses answer with an error and no write
		mapped   = (paddr == wdt_wake_pkg::CONFIG_OFFSET)
			| (paddr == wdt_wake_pkg::WAKE_MASK_OFFSET)
			| (paddr == wdt_wake_pkg::STATUS_OFFSET)
			| (paddr == wdt_wake_pkg::COUNT_OFFSET);
		r_next.pready  = setup_ph;
		r_next.pslverr = setup_ph & ~mapped;
		if (setup_ph) begin
			r_next.prdata = 32'h0000_0000;
			case (paddr)
				wdt_wake_pkg::CONFIG_OFFSET: begin
					r_next.prdata[3:0] = r_reg.cfg;
				end
				wdt_wake_pkg::WAKE_MASK_OFFSET: begin
					r_next.prdata[wdt_wake_pkg::MASK_PORT_A_LSB +: 8] = r_reg.mask_a;
					r_next.prdata[wdt_wake_pkg::MASK_NIBBLE_LSB +: OTHER_NIBBLES] = r_reg.mask_nib;
				end
				wdt_wake_pkg::STATUS_OFFSET: begin
					r_next.prdata[wdt_wake_pkg::STAT_TIMEOUT_BIT] = r_reg.timeout_flag;
					r_next.prdata[wdt_wake_pkg::STAT_PDOWN_BIT]   = r_reg.powerdown_flag;
					r_next.prdata[wdt_wake_pkg::STAT_CAUSE_LSB +: 3] = r_reg.cause;
					r_next.prdata[wdt_wake_pkg::STAT_STATE_LSB +: 2] = r_reg.state;
				end
				wdt_wake_pkg::COUNT_OFFSET: begin
					r_next.prdata[6:0] = {r_reg.final_bit, r_reg.prescale};
				end
				default: begin
					r_next.prdata = 32'h0000_0000;
				end
			endcase
		end
		if (wr_take && paddr == wdt_wake_pkg::CONFIG_OFFSET) begin
			r_next.cfg = pwdata[3:0];
		end
		if (wr_take && paddr == wdt_wake_pkg::WAKE_MASK_OFFSET) begin
			r_next.mask_a   = pwdata[wdt_wake_pkg::MASK_PORT_A_LSB +: 8];
			r_next.mask_nib = pwdata[wdt_wake_pkg::MASK_NIBBLE_LSB +: OTHER_NIBBLES];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			r_reg                <= '0;
			r_reg.cfg            <= wdt_wake_pkg::CONFIG_RESET;
			r_reg.mask_a         <= wdt_wake_pkg::MASK_PORT_A_RESET;
			r_reg.rn_s1          <= 1'b1;
			r_reg.rn_s2          <= 1'b1;
			// Pins idle high: edge history starts high, so no false edge
			r_reg.a_s1           <= 8'hFF;
			r_reg.a_s2           <= 8'hFF;
			r_reg.a_prev         <= 8'hFF;
			r_reg.o_s1           <= '1;
			r_reg.o_s2           <= '1;
			r_reg.o_prev         <= '1;
			r_reg.state          <= wdt_wake_pkg::ST_RUN;
			r_reg.cause          <= wdt_wake_pkg::CAUSE_NONE;
			r_reg.pair           <= wdt_wake_pkg::PAIR_NONE;
			r_reg.sys_osc_run    <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Every output is a flip-flop of the state record
	assign prdata             = r_reg.prdata;
	assign pready             = r_reg.pready;
	assign pslverr            = r_reg.pslverr;
	assign timeout_flag       = r_reg.timeout_flag;
	assign powerdown_flag     = r_reg.powerdown_flag;
	assign core_stall         = r_reg.core_stall;
	assign sys_osc_run        = r_reg.sys_osc_run;
	assign system_reset_req   = r_reg.system_reset_req;
	assign watchdog_reset_req = r_reg.watchdog_reset_req;
	assign pc_sp_reset_req    = r_reg.pc_sp_reset_req;
	assign resume_req         = r_reg.resume_req;
	assign irq_service_req    = r_reg.irq_service_req;

endmodule : watchdog_and_wakeup_control

`default_nettype wire

// *** sim/watchdog_and_wakeup_control_asserts.sv ***
// Purpose: Port-level assertions for the watchdog and wake-up controller.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Wake counter restarts while the system oscillator is off.
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_wakeup_control_asserts (
	input wire logic clock,              // System clock
	input wire logic rst,                // Sync reset
	input wire logic sleep_instr,        // Sleep strobe
	input wire logic timeout_flag,       // Time-out status
	input wire logic powerdown_flag,     // Power-down status
	input wire logic core_stall,         // Core held off
	input wire logic sys_osc_run,        // Oscillator enable
	input wire logic system_reset_req,   // Full reset pulse
	input wire logic watchdog_reset_req, // Device reset pulse
	input wire logic pc_sp_reset_req,    // Warm reset pulse
	input wire logic resume_req,         // Resume pulse
	input wire logic irq_service_req     // Interrupt entry pulse
);
	logic [10:0] wake_cnt_reg;
	logic [10:0] wake_cnt_next;
	always_comb begin
		wake_cnt_next = wake_cnt_reg;
		if (!sys_osc_run)
			wake_cnt_next = 11'h000;
		else if (wake_cnt_reg != 11'h7FF)
			wake_cnt_next = wake_cnt_reg + 11'h001;
	end
	always_ff @(posedge clock) begin
		if (rst)
			wake_cnt_reg <= 11'h000;
		else
			wake_cnt_reg <= wake_cnt_next;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	AST_SLEEP_ENTRY: assert property (sleep_instr && !core_stall |=> watchdog_reset_req ||
		(powerdown_flag && !timeout_flag && core_stall && !sys_osc_run)) else $error("sleep entry");
	AST_STARTUP_LEN: assert property (resume_req || pc_sp_reset_req || system_reset_req
		|-> wake_cnt_reg == 11'h400) else $error("start-up length");
	AST_IRQ_ENTRY: assert property (irq_service_req |-> wake_cnt_reg == 11'h401)
		else $error("interrupt entry timing");
	AST_STALL_RELEASE: assert property ($fell(core_stall) |-> wake_cnt_reg >= 11'h400)
		else $error("stall released early");
	AST_OSC_STOP: assert property (!sys_osc_run |-> core_stall) else $error("osc off, core free");
	AST_WDT_PULSE: assert property (watchdog_reset_req |=> !watchdog_reset_req)
		else $error("reset pulse too long");
	AST_WDT_FLAG: assert property (watchdog_reset_req |-> timeout_flag) else $error("flag");
	AST_WARM_FLAGS: assert property (pc_sp_reset_req |-> timeout_flag && powerdown_flag)
		else $error("warm reset flags");
	AST_PIN_RESUME: assert property (resume_req |-> !(system_reset_req || pc_sp_reset_req ||
		watchdog_reset_req)) else $error("resume with reset");
	AST_EXT_WAKE: assert property (system_reset_req |-> !powerdown_flag && !timeout_flag)
		else $error("external wake flags");
	cover property (resume_req);
	cover property (pc_sp_reset_req);
	cover property (irq_service_req);
	cover property (system_reset_req);
endmodule : watchdog_and_wakeup_control_asserts
bind watchdog_and_wakeup_control watchdog_and_wakeup_control_asserts
	watchdog_and_wakeup_control_asserts_inst (.clock(clock), .rst(rst), .sleep_instr(sleep_instr),
	.timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .core_stall(core_stall),
	.sys_osc_run(sys_osc_run), .system_reset_req(system_reset_req),
	.watchdog_reset_req(watchdog_reset_req), .pc_sp_reset_req(pc_sp_reset_req),
	.resume_req(resume_req), .irq_service_req(irq_service_req));
`default_nettype wire

// *** sim/core_model.sv ***
// Purpose: Processor core issuing clear and sleep instructions.
// Assumes: One-cycle strobes, launched only while the core is not stalled.
// Notes:   Codes: 0 single clear, 1 first, 2 second, 3 sleep.
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic clock,                 // System clock
	input wire logic core_stall,            // Core held off
	output logic     watchdog_clear_single, // Single clear
	output logic     watchdog_clear_first,  // First paired clear
	output logic     watchdog_clear_second, // Second paired clear
	output logic     sleep_instr            // Sleep
);
	initial begin
		watchdog_clear_single = 1'b0;
		watchdog_clear_first = 1'b0;
		watchdog_clear_second = 1'b0;
		sleep_instr = 1'b0;
	end
	task automatic issue(input logic [1:0] k);
		@(posedge clock);
		while (core_stall)
			@(posedge clock);
		case (k)
			2'h0: watchdog_clear_single <= 1'b1;
			2'h1: watchdog_clear_first <= 1'b1;
			2'h2: watchdog_clear_second <= 1'b1;
			default: sleep_instr <= 1'b1;
		endcase
		@(posedge clock);
		{watchdog_clear_single, watchdog_clear_first, watchdog_clear_second, sleep_instr} <= 4'h0;
	endtask : issue
endmodule : core_model
`default_nettype wire

// *** sim/watchdog_and_wakeup_control_tb_top.sv ***
// Purpose: Self-checking bench for the watchdog and wake-up controller.
// Assumes: Expected outcome pulses queued by the stimulus before each wake.
// Notes:   Watchdog oscillator is gated so that no overflow lands mid start-up.
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_wakeup_control_tb_top;
	logic        clock, rst, psel, penable, pwrite, wdt_osc, ext_reset_n;
	logic        irq_request, irq_enabled, stack_full, pready, pslverr, osc_en, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, seed;
	logic [7:0]  port_a_pins;
	logic [27:0] port_other_pins;
	logic        clr_s, clr_f, clr_t, sleep_i, timeout_flag, powerdown_flag, core_stall, sys_osc_run;
	wire  [4:0]  pulses;
	logic [4:0]  exp_ev[$];
	int          bad_count, n_checks;
	watchdog_and_wakeup_control watchdog_and_wakeup_control_inst (.clock(clock), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_osc(wdt_osc),
		.ext_reset_n(ext_reset_n), .port_a_pins(port_a_pins), .port_other_pins(port_other_pins),
		.irq_request(irq_request), .irq_enabled(irq_enabled), .stack_full(stack_full),
		.watchdog_clear_single(clr_s), .watchdog_clear_first(clr_f),
		.watchdog_clear_second(clr_t), .sleep_instr(sleep_i), .timeout_flag(timeout_flag),
		.powerdown_flag(powerdown_flag), .core_stall(core_stall), .sys_osc_run(sys_osc_run),
		.watchdog_reset_req(pulses[0]), .resume_req(pulses[1]), .system_reset_req(pulses[2]),
		.pc_sp_reset_req(pulses[3]), .irq_service_req(pulses[4]));
	core_model core_model_inst (.clock(clock), .core_stall(core_stall),
		.watchdog_clear_single(clr_s), .watchdog_clear_first(clr_f),
		.watchdog_clear_second(clr_t), .sleep_instr(sleep_i));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0);
		chk(q, x);
		chk(32'(e), 32'(xe));
	endtask : rd
	// Flags as {timeout, powerdown, stall, osc run}
	task automatic st(input logic [3:0] x);
		@(negedge clock);
		chk(32'({timeout_flag, powerdown_flag, core_stall, sys_osc_run}), 32'(x));
		@(posedge clock);
	endtask : st
	task automatic wait_ev();
		int n;
		n = 0;
		while (exp_ev.size() != 0 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		chk(32'(exp_ev.size()), 32'h0);
	endtask : wait_ev
	always @(posedge clock) begin
		if (!rst && pulses !== 5'h00)
			chk(32'(pulses), exp_ev.size() != 0 ? 32'(exp_ev.pop_front()) : 32'h0);
	end
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Pin toggles only while osc_en is set, unrelated in phase to the system clock
	initial begin
		wdt_osc = 1'b0;
		#1.3;
		forever #3 if (osc_en) wdt_osc = ~wdt_osc;
	end
	initial begin
		repeat (40000) @(posedge clock);
		bad_count++;
		close_out();
	end
	initial begin
		seed = 32'hB69D866C;
		{rst, psel, penable, osc_en} = 4'b1000;
		{pwrite, paddr, pwdata} = {seed[0], seed[11:0], seed};
		{ext_reset_n, irq_request, irq_enabled, stack_full} = seed[31:28];
		{port_a_pins, port_other_pins} = {seed[7:0], seed[27:0]};
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		{ext_reset_n, irq_request, irq_enabled, stack_full} <= 4'b1000;
		rd(wdt_wake_pkg::CONFIG_OFFSET, 32'h3, 1'b0);
		rd(wdt_wake_pkg::STATUS_OFFSET, 32'h0, 1'b0);
		rd(12'h010, 32'h0, 1'b1);
		seed = xs(seed);
		apb(1'b1, wdt_wake_pkg::WAKE_MASK_OFFSET, seed);
		rd(wdt_wake_pkg::WAKE_MASK_OFFSET, seed & 32'h7FFF, 1'b0);
		apb(1'b1, wdt_wake_pkg::WAKE_MASK_OFFSET, 32'h1);
		core_model_inst.issue(2'h3);
		st(4'b0110);
		repeat (20) begin
			@(posedge clock);
			seed = xs(seed);
			port_other_pins <= seed[27:0];
			port_a_pins <= {seed[31:29], 5'h1F};
		end
		st(4'b0110);
		exp_ev.push_back(5'h02);
		port_a_pins <= 8'hFE;
		wait_ev();
		st(4'b0101);
		port_a_pins <= 8'hFF;
		apb(1'b1, wdt_wake_pkg::CONFIG_OFFSET, 32'h2);
		core_model_inst.issue(2'h0);
		st(4'b0101);
		apb(1'b1, wdt_wake_pkg::CONFIG_OFFSET, 32'hB);
		core_model_inst.issue(2'h1);
		core_model_inst.issue(2'h1);
		st(4'b0101);
		core_model_inst.issue(2'h2);
		st(4'b0001);
		apb(1'b1, wdt_wake_pkg::CONFIG_OFFSET, 32'h3);
		exp_ev.push_back(5'h01);
		osc_en <= 1'b1;
		wait_ev();
		st(4'b1001);
		repeat (20) begin
			core_model_inst.issue(2'h0);
			repeat (30) @(posedge clock);
		end
		apb(1'b1, wdt_wake_pkg::CONFIG_OFFSET, 32'h1);
		repeat (600) @(posedge clock);
		st(4'b1001);
		apb(1'b1, wdt_wake_pkg::CONFIG_OFFSET, 32'h3);
		exp_ev.push_back(5'h08);
		core_model_inst.issue(2'h3);
		st(4'b0110);
		for (int i = 0; i < 2000 && sys_osc_run !== 1'b1; i++)
			@(posedge clock);
		osc_en <= 1'b0;
		wait_ev();
		st(4'b1101);
		irq_enabled <= 1'b1;
		core_model_inst.issue(2'h3);
		repeat (5) @(posedge clock);
		exp_ev.push_back(5'h10);
		irq_request <= 1'b1;
		wait_ev();
		st(4'b0101);
		for (int k = 0; k < 2; k++) begin
			irq_request <= 1'b0;
			irq_enabled <= k[0];
			stack_full <= k[0];
			core_model_inst.issue(2'h3);
			repeat (5) @(posedge clock);
			exp_ev.push_back(5'h02);
			irq_request <= 1'b1;
			wait_ev();
		end
		apb(1'b1, wdt_wake_pkg::CONFIG_OFFSET, 32'h5);
		exp_ev.push_back(5'h01);
		wait_ev();
		core_model_inst.issue(2'h3);
		repeat (600) @(posedge clock);
		st(4'b0110);
		irq_request <= 1'b0;
		exp_ev.push_back(5'h04);
		ext_reset_n <= 1'b0;
		repeat (5) @(posedge clock);
		ext_reset_n <= 1'b1;
		wait_ev();
		st(4'b0001);
		close_out();
	end
endmodule : watchdog_and_wakeup_control_tb_top
`default_nettype wire
